// *** core/stepper_drive_control_word.sv ***
// Purpose: Serial word capture and drive control word decode for a stepper driver
// Assumes: Serial and step pins are asynchronous; synchronised here
// Notes:   Position unit is 1/256 of a quarter electrical period
`timescale 1ns/100ps
`default_nettype none
module stepper_drive_control_word
  import step_drive_pkg::*;
#(
  parameter int unsigned POS_BITS = 10
) (
  // Clock, reset, enable
  input  wire logic         sys_clk_in,
  input  wire logic         reset_in,
  input  wire logic         clk_en_in,
  // Serial port pins
  input  wire logic         spi_sck_in,
  input  wire logic         spi_cs_n_in,
  input  wire logic         spi_mosi_in,
  // Step/direction pins
  input  wire logic         step_in,
  input  wire logic         dir_in,
  // Coil drive
  output coil_drive_t       coil_a_out,
  output coil_drive_t       coil_b_out,
  output logic              step_input_disable_out,
  // Step interface state
  output step_config_t      step_config_out,
  output logic [POS_BITS-1:0] microstep_position_out,
  output logic              word_loaded_out
);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_LOAD  = 3'b100
  } frame_state_t;

  // Stride for a resolution code, saturating beyond full step
  function automatic logic [8:0] stride_of(input logic [3:0] res);
    logic [3:0] r;
    r = (res > MICROSTEP_RESOLUTION_FULL) ? MICROSTEP_RESOLUTION_FULL : res;
    return 9'(9'h001 << r);
  endfunction

  // Two-flop synchronisers
  logic [1:0] sck_sync_ff;
  logic [1:0] cs_sync_ff;
  logic [1:0] mosi_sync_ff;
  logic [1:0] step_sync_ff;
  logic [1:0] dir_sync_ff;
  logic       sck_prev_ff;
  logic       step_prev_ff;

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      sck_sync_ff  <= 2'h0;
      cs_sync_ff   <= 2'h3;
      mosi_sync_ff <= 2'h0;
      step_sync_ff <= 2'h0;
      dir_sync_ff  <= 2'h0;
      sck_prev_ff  <= 1'b0;
      step_prev_ff <= 1'b0;
    end else if (clk_en_in) begin
      sck_sync_ff  <= {sck_sync_ff[0], spi_sck_in};
      cs_sync_ff   <= {cs_sync_ff[0], spi_cs_n_in};
      mosi_sync_ff <= {mosi_sync_ff[0], spi_mosi_in};
      step_sync_ff <= {step_sync_ff[0], step_in};
      dir_sync_ff  <= {dir_sync_ff[0], dir_in};
      sck_prev_ff  <= sck_sync_ff[1];
      step_prev_ff <= step_sync_ff[1];
    end
  end

  wire sck_s    = sck_sync_ff[1];
  wire cs_n_s   = cs_sync_ff[1];
  wire mosi_s   = mosi_sync_ff[1];
  wire step_s   = step_sync_ff[1];
  wire dir_s    = dir_sync_ff[1];
  wire sck_rise = sck_s && !sck_prev_ff;

  // Frame state machine and shift register
  frame_state_t state_ff;
  frame_state_t nxt_state;
  logic [WORD_BITS-1:0] shift_ff;

  always_comb begin
    case (state_ff)
      ST_IDLE:  nxt_state = cs_n_s ? ST_IDLE : ST_SHIFT;
      ST_SHIFT: nxt_state = cs_n_s ? ST_LOAD : ST_SHIFT;
      ST_LOAD:  nxt_state = ST_IDLE;
      default:  nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state_ff <= ST_IDLE;
      shift_ff <= '0;
    end else if (clk_en_in) begin
      state_ff <= nxt_state;
      // Older bits fall off the top, only the newest 20 survive
      if (state_ff == ST_SHIFT && !cs_n_s && sck_rise) begin
        shift_ff <= {shift_ff[WORD_BITS-2:0], mosi_s};
      end
    end
  end

  // Word selection at chip-select release
  wire load_now    = (state_ff == ST_LOAD);
  wire sel_drive   = (shift_ff[SEL_HI:SEL_LO] == SEL_DRIVE_CONTROL);
  wire sel_config  = (shift_ff[SEL_HI:SEL_HI-2] == SEL_DRIVER_CONFIG);
  wire load_drive  = load_now && sel_drive;
  wire load_config = load_now && sel_config;

  logic [WORD_BITS-1:0] drive_word_ff;
  logic [WORD_BITS-1:0] config_word_ff;
  logic                 loaded_ff;

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      drive_word_ff  <= DRIVE_WORD_RESET;
      config_word_ff <= CONFIG_WORD_RESET;
      loaded_ff      <= 1'b0;
    end else if (clk_en_in) begin
      loaded_ff <= load_drive;
      if (load_drive) begin
        drive_word_ff <= shift_ff;
      end
      if (load_config) begin
        config_word_ff <= shift_ff;
      end
    end
  end

  wire step_input_disable = config_word_ff[SD_DISABLE_BIT];

  // Direct-current decode
  coil_drive_t dc_a;
  coil_drive_t dc_b;
  assign dc_a.pol = drive_word_ff[POL_A_BIT];
  assign dc_a.mag = drive_word_ff[MAG_A_HI:MAG_A_LO];
  assign dc_b.pol = drive_word_ff[POL_B_BIT];
  assign dc_b.mag = drive_word_ff[MAG_B_HI:MAG_B_LO];
  // Magnitudes pass unclipped; headroom for offset is the host's job

  // Step/direction configuration decode
  step_config_t sd_cfg;
  assign sd_cfg.interpolate = drive_word_ff[INTERP_BIT];
  assign sd_cfg.both_edges  = drive_word_ff[BOTH_EDGE_STEPPING_BIT];
  assign sd_cfg.resolution  = drive_word_ff[MICROSTEP_RESOLUTION_HI:MICROSTEP_RESOLUTION_LO];
  // Unused bits are not checked, host leaves them zero

  // Step edge detection
  wire step_rise   = step_s && !step_prev_ff;
  wire step_fall   = !step_s && step_prev_ff;
  wire step_edge   = step_rise || (sd_cfg.both_edges && step_fall);
  wire step_active = !step_input_disable && step_edge;

  // Interpolated substeps
  wire sub_step;
  step_interp #(
    .GAP_CYC (INTERP_GAP_CYC)
  ) u_interp (
    .sys_clk_in   (sys_clk_in),
    .reset_in     (reset_in),
    .clk_en_in    (clk_en_in),
    .step_in      (step_active && sd_cfg.interpolate),
    .sub_step_out (sub_step)
  );

  // Interpolation moves in sixteen parts of a sixteenth of the stride each, never less than one unit
  wire [8:0] base_stride = stride_of(sd_cfg.resolution);
  wire [8:0] sub_stride  = (base_stride >> 4) == 9'h000 ? 9'h001 : (base_stride >> 4);
  wire       adv         = sd_cfg.interpolate ? (sub_step && !step_input_disable)
                                              : step_active;
  wire [8:0] stride_now  = sd_cfg.interpolate ? sub_stride : base_stride;

  logic [POS_BITS-1:0] pos_ff;
  logic [POS_BITS-1:0] nxt_pos;

  always_comb begin
    nxt_pos = pos_ff;
    if (adv) begin
      if (dir_s) begin
        nxt_pos = pos_ff - POS_BITS'(stride_now);
      end else begin
        nxt_pos = pos_ff + POS_BITS'(stride_now);
      end
    end
  end

  // Outputs registered; step inputs ignored in direct mode
  coil_drive_t  coil_a_ff;
  coil_drive_t  coil_b_ff;
  step_config_t cfg_ff;

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      pos_ff    <= '0;
      coil_a_ff <= '0;
      coil_b_ff <= '0;
      cfg_ff    <= '0;
    end else if (clk_en_in) begin
      pos_ff <= nxt_pos;
      if (step_input_disable) begin
        coil_a_ff <= dc_a;
        coil_b_ff <= dc_b;
        cfg_ff    <= '0;
      end else begin
        coil_a_ff <= '0;
        coil_b_ff <= '0;
        cfg_ff    <= sd_cfg;
      end
    end
  end

  assign coil_a_out             = coil_a_ff;
  assign coil_b_out             = coil_b_ff;
  assign step_config_out        = cfg_ff;
  assign step_input_disable_out = step_input_disable;
  assign microstep_position_out = pos_ff;
  assign word_loaded_out        = loaded_ff;

endmodule // stepper_drive_control_word
`default_nettype wire

// *** core/step_drive_pkg.sv ***
// Purpose: Shared constants and types for the drive control word decoder
// Assumes: 20-bit serial words, system clock 100 MHz
// Notes:   Field positions of both control word formats
package step_drive_pkg;

  localparam int unsigned WORD_BITS = 20;
  // Register select field
  localparam int unsigned SEL_HI = 19;
  localparam int unsigned SEL_LO = 18;
  localparam logic [1:0] SEL_DRIVE_CONTROL = 2'h0;
  localparam logic [2:0] SEL_DRIVER_CONFIG = 3'h7;
  // Direct-current format
  localparam int unsigned POL_A_BIT = 17;
  localparam int unsigned MAG_A_HI  = 16;
  localparam int unsigned MAG_A_LO  = 9;
  localparam int unsigned POL_B_BIT = 8;
  localparam int unsigned MAG_B_HI  = 7;
  localparam int unsigned MAG_B_LO  = 0;
  // Step/direction format
  localparam int unsigned INTERP_BIT = 9;
  localparam int unsigned BOTH_EDGE_STEPPING_BIT  = 8;
  localparam int unsigned MICROSTEP_RESOLUTION_HI    = 3;
  localparam int unsigned MICROSTEP_RESOLUTION_LO    = 0;
  localparam logic [3:0]  MICROSTEP_RESOLUTION_FULL  = 4'h8;
  localparam int unsigned INTERP_SUBSTEPS = 16;
  // Driver configuration word
  localparam int unsigned SD_DISABLE_BIT = 7;
  // Reset values
  localparam logic [19:0] DRIVE_WORD_RESET  = 20'h00000;
  localparam logic [19:0] CONFIG_WORD_RESET = 20'h00000;
  // Interpolation: substep spacing in system clocks
  localparam int unsigned INTERP_GAP_NS  = 1000;
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned INTERP_GAP_CYC = INTERP_GAP_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic       pol;
    logic [7:0] mag;
  } coil_drive_t;

  typedef struct packed {
    logic       interpolate;
    logic       both_edges;
    logic [3:0] resolution;
  } step_config_t;

endpackage

// *** core/step_interp.sv ***
// Purpose: Splits one step into sixteen evenly spaced substeps
// Assumes: Same clock domain as the caller
// Notes:   A step arriving mid-burst restarts the burst
`timescale 1ns/100ps
`default_nettype none
module step_interp
  import step_drive_pkg::*;
#(
  parameter int unsigned GAP_CYC = INTERP_GAP_CYC
) (
  // Clock and reset
  input  wire logic sys_clk_in,
  input  wire logic reset_in,
  input  wire logic clk_en_in,
  // Step in, substeps out
  input  wire logic step_in,
  output logic      sub_step_out
);

  logic [4:0]  left_ff;
  logic [15:0] gap_ff;
  wire         gap_done = (gap_ff == 16'h0000);

  assign sub_step_out = (left_ff != 5'h00) && gap_done && !step_in;

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      left_ff <= 5'h00;
      gap_ff  <= 16'h0000;
    end else if (clk_en_in) begin
      if (step_in) begin
        left_ff <= 5'(INTERP_SUBSTEPS);
        gap_ff  <= 16'h0000;
      end else if (sub_step_out) begin
        left_ff <= left_ff - 5'h01;
        gap_ff  <= 16'(GAP_CYC - 1);
      end else if (!gap_done) begin
        gap_ff <= gap_ff - 16'h0001;
      end
    end
  end

endmodule // step_interp
`default_nettype wire

// *** tb/drive_host.sv ***
// Purpose: Host model driving serial frames and step pulses
// Assumes: Serial clock idles low and stands still between frames
// Notes:   Data line shows the inverse of its last bit once released
`timescale 1ns/100ps
`default_nettype none
module drive_host (
  // Clock
  input  wire logic sys_clk_in,
  // Pins toward the device
  output logic      spi_sck_out,
  output logic      spi_cs_n_out,
  output logic      spi_mosi_out,
  output logic      step_out,
  output logic      dir_out
);
  initial begin
    spi_sck_out = 1'b0;
    spi_cs_n_out = 1'b1;
    spi_mosi_out = 1'b0;
    step_out = 1'b0;
    dir_out = 1'b0;
  end
  // Half of a 160 ns serial period
  task automatic half;
    repeat (8) @(negedge sys_clk_in);
  endtask
  // Longer frames are legal: only the last bits count
  task automatic send(input logic [23:0] w, input int n);
    spi_cs_n_out = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      spi_mosi_out = w[i];
      half();
      spi_sck_out = 1'b1;
      half();
      spi_sck_out = 1'b0;
    end
    spi_mosi_out = ~spi_mosi_out;
    half();
    spi_cs_n_out = 1'b1;
    half();
    half();
  endtask
  // Toggles the step line n times
  task automatic pulse(input logic d, input int n);
    dir_out = d;
    for (int i = 0; i < n; i++) begin
      half();
      step_out = ~step_out;
    end
    half();
  endtask
endmodule // drive_host
`default_nettype wire

// *** tb/drive_word_checker.sv ***
// Purpose: Port timing checks for the drive control word decoder
// Assumes: One clock domain, synchronous reset
// Notes:   Stride checks assume config is steady while stepping
`timescale 1ns/100ps
`default_nettype none
module drive_word_checker
  import step_drive_pkg::*;
#(
  parameter int unsigned POS_BITS = 10
) (
  // Clock
  input wire logic                sys_clk_in,
  input wire logic                reset_in,
  // Watched
  input wire logic                spi_cs_n_in,
  input wire logic                dir_in,
  input wire coil_drive_t         coil_a_out,
  input wire coil_drive_t         coil_b_out,
  input wire logic                step_input_disable_out,
  input wire step_config_t        step_config_out,
  input wire logic [POS_BITS-1:0] microstep_position_out,
  input wire logic                word_loaded_out
);
  logic [3:0]          res;
  logic [POS_BITS-1:0] stride;
  logic [POS_BITS-1:0] sub;
  assign res = (step_config_out.resolution > MICROSTEP_RESOLUTION_FULL) ? MICROSTEP_RESOLUTION_FULL : step_config_out.resolution;
  assign stride = POS_BITS'(1) << res;
  assign sub = (res > 4'h4) ? (stride >> 4) : POS_BITS'(1);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  coil_quiet_a: assert property (
    !step_input_disable_out && !$past(step_input_disable_out) |->
    coil_a_out == 9'h0 && coil_b_out == 9'h0) else $error("coil drive in step mode");
  config_quiet_a: assert property (
    step_input_disable_out && $past(step_input_disable_out) |->
    step_config_out == 6'h0) else $error("step config in direct mode");
  load_pulse_a: assert property (
    word_loaded_out |=> !word_loaded_out) else $error("load pulse too long");
  load_after_cs_a: assert property (
    word_loaded_out |-> spi_cs_n_in && $past(spi_cs_n_in, 3)) else $error("load without cs rise");
  coil_cause_a: assert property (
    $changed(coil_a_out) |-> word_loaded_out || $past(word_loaded_out) ||
    $changed(step_input_disable_out) || $past(step_input_disable_out) !=
    $past(step_input_disable_out, 2)) else $error("coil change without cause");
  pos_hold_a: assert property (
    step_input_disable_out [*6] |-> $stable(microstep_position_out)) else $error("moved when off");
  step_stride_a: assert property (
    $changed(microstep_position_out) && !step_config_out.interpolate |->
    POS_BITS'(microstep_position_out - $past(microstep_position_out)) ==
    ($past(dir_in, 4) ? POS_BITS'(-stride) : stride)) else $error("bad step stride");
  sub_stride_a: assert property (
    $changed(microstep_position_out) && step_config_out.interpolate |->
    POS_BITS'(microstep_position_out - $past(microstep_position_out)) ==
    ($past(dir_in, 4) ? POS_BITS'(-sub) : sub)) else $error("bad substep stride");
endmodule // drive_word_checker
bind stepper_drive_control_word drive_word_checker #(.POS_BITS(POS_BITS)) chk (
  .sys_clk_in, .reset_in, .spi_cs_n_in, .dir_in, .coil_a_out, .coil_b_out,
  .step_input_disable_out, .step_config_out, .microstep_position_out, .word_loaded_out);
`default_nettype wire

// *** tb/tb.sv ***
// Purpose: Self-checking bench for the drive control word decoder
// Assumes: Host model drives serial and step pins
// Notes:   Direct-current cases run from a table
`timescale 1ns/100ps
`default_nettype none
module tb
  import step_drive_pkg::*;
;
  logic sys_clk_in;
  logic reset_in;
  logic spi_sck_in;
  logic spi_cs_n_in;
  logic spi_mosi_in;
  logic step_in;
  logic dir_in;
  coil_drive_t coil_a_out;
  coil_drive_t coil_b_out;
  logic step_input_disable_out;
  step_config_t step_config_out;
  logic [9:0] microstep_position_out;
  logic word_loaded_out;
  int n_fail = 0;
  int compares = 0;
  int n_load = 0;
  coil_drive_t rows [4][2] = '{'{9'h080, 9'h101}, '{9'h1f8, 9'h07f},
    '{9'h100, 9'h1f8}, '{9'h055, 9'h0aa}};
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  drive_host host (.sys_clk_in, .spi_sck_out(spi_sck_in), .spi_cs_n_out(spi_cs_n_in),
    .spi_mosi_out(spi_mosi_in), .step_out(step_in), .dir_out(dir_in));
  stepper_drive_control_word dut (.sys_clk_in, .reset_in, .clk_en_in(1'b1), .spi_sck_in,
    .spi_cs_n_in, .spi_mosi_in, .step_in, .dir_in, .coil_a_out, .coil_b_out,
    .step_input_disable_out, .step_config_out, .microstep_position_out, .word_loaded_out);
  always @(posedge sys_clk_in) if (word_loaded_out === 1'b1) n_load++;
  task automatic check(input string what, input logic [19:0] exp, input logic [19:0] got);
    compares++;
    if (exp !== got) begin
      $display("FAIL %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic stepping(input logic ip, input logic de, input logic [3:0] res,
                          input logic d, input int n, input logic [9:0] delta);
    logic [9:0] p0;
    host.send({2'b00, 8'h00, ip, de, 4'h0, res}, 20);
    check("step config", {ip, de, res}, step_config_out);
    p0 = microstep_position_out;
    host.pulse(d, n);
    if (ip) repeat (17 * INTERP_GAP_CYC) @(negedge sys_clk_in);
    // Cut to the counter width so wrap-around compares like the design
    check("position", 10'(p0 + delta), microstep_position_out);
  endtask
  initial begin
    #500000;
    $display("FAIL watchdog expected end seen hang");
    n_fail++;
    wrap_up();
  end
  initial begin
    reset_in = 1'b1;
    repeat (8) @(negedge sys_clk_in);
    reset_in = 1'b0;
    check("coils", {coil_a_out, coil_b_out}, 18'h0);
    check("state", {step_input_disable_out, step_config_out, microstep_position_out}, 17'h0);
    repeat (3) @(negedge sys_clk_in);
    host.send(20'he0080, 20);
    check("disable", 1'b1, step_input_disable_out);
    foreach (rows[i]) begin
      host.send({2'b00, rows[i][0], rows[i][1]}, 20);
      check("coil a", rows[i][0], coil_a_out);
      check("coil b", rows[i][1], coil_b_out);
    end
    check("loads", 20'(n_load), 20'h4);
    $display("direct table done");
    host.send(20'h5ffff, 20);
    check("refused", rows[3][0], coil_a_out);
    host.send({4'hf, 2'b00, 9'h1ab, 9'h0cd}, 24);
    check("long frame", {coil_a_out, coil_b_out}, {9'h1ab, 9'h0cd});
    host.pulse(1'b0, 4);
    check("no step", 10'h0, microstep_position_out);
    host.send(20'he0000, 20);
    check("coils off", {coil_a_out, coil_b_out}, 18'h0);
    $display("direct edge cases done");
    for (int r = 0; r <= 8; r++) begin
      stepping(1'b0, 1'b0, r[3:0], 1'b0, 2, 10'h1 << r);
      stepping(1'b0, 1'b0, r[3:0], 1'b1, 2, -(10'h1 << r));
    end
    stepping(1'b0, 1'b1, 4'h8, 1'b0, 2, 10'h200);
    stepping(1'b1, 1'b0, 4'h4, 1'b0, 1, 10'h010);
    $display("step tests done");
    // Reset in mid-run, then a frame three cycles after release
    @(negedge sys_clk_in);
    reset_in = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    reset_in = 1'b0;
    check("reset position", 10'h0, microstep_position_out);
    check("reset config", 6'h0, step_config_out);
    repeat (3) @(negedge sys_clk_in);
    host.send({2'b00, 8'h00, 1'b0, 1'b1, 4'h0, 4'h3}, 20);
    check("config after reset", 6'h13, step_config_out);
    $display("mid-run reset done");
    wrap_up();
  end
endmodule // tb
`default_nettype wire
